// [hw/dfcr_consts.svh]
// offsets, field positions, masks and reset values of the drive fault and command registers
`ifndef DFCR_CONSTS_SVH
`define DFCR_CONSTS_SVH

`define DFCR_BCAST_ADDR      8'h00

`define DFCR_ADDR_CMD        16'h0001
`define DFCR_ADDR_FREQ       16'h0002
`define DFCR_ADDR_INEN       16'h000F
`define DFCR_ADDR_HW1        16'h00D0
`define DFCR_ADDR_HW2        16'h00D1
`define DFCR_ADDR_OPT        16'h00D8
`define DFCR_ADDR_CURRENT    16'h00FB
`define DFCR_ADDR_COMM_LOG   16'h00FD

`define DFCR_CMD_RUN_BIT     0
`define DFCR_CMD_DIR_BIT     1
`define DFCR_CMD_EXTF_BIT    4
`define DFCR_CMD_FRST_BIT    5
`define DFCR_CMD_MFI5_BIT    12
`define DFCR_CMD_MFI6_BIT    13
`define DFCR_CMD_MFI7_BIT    14
`define DFCR_CMD_MASK        16'h7033
`define DFCR_INEN_MASK       16'h7000

`define DFCR_HW1_ADC_BIT     2
`define DFCR_HW1_PWMD_BIT    3
`define DFCR_HW1_SPEC_BIT    6
`define DFCR_HW1_TBCOM_BIT   7
`define DFCR_HW1_EEP_BIT     8
`define DFCR_HW1_RAM_BIT     11
`define DFCR_HW1_FLASH_BIT   12
`define DFCR_HW1_WDOG_BIT    13
`define DFCR_HW1_CCA_BIT     14
`define DFCR_HW1_MASK        16'h79CC

`define DFCR_HW2_CLK_BIT     0
`define DFCR_HW2_TIM_BIT     1
`define DFCR_HW2_CCB_BIT     2
`define DFCR_HW2_CCC_BIT     3
`define DFCR_HW2_PWRUP_BIT   4
`define DFCR_HW2_COMST_BIT   5
`define DFCR_HW2_CONV_BIT    6
`define DFCR_HW2_PWMFB_BIT   7
`define DFCR_HW2_CAP_BIT     8
`define DFCR_HW2_TBUNC_BIT   9
`define DFCR_HW2_MASK        16'h03FF

`define DFCR_OPT_INCOMP_BIT  0
`define DFCR_OPT_UNCON_BIT   1
`define DFCR_OPT_SELF_BIT    3
`define DFCR_OPT_FLASH_BIT   4
`define DFCR_OPT_MASK        16'h001B

`define DFCR_LOG_CRC_BIT     0
`define DFCR_LOG_PAR_BIT     1
`define DFCR_LOG_FRM_BIT     2
`define DFCR_LOG_OVR_BIT     3
`define DFCR_LOG_TMO_BIT     4
`define DFCR_LOG_MASK        16'h001F

`define DFCR_CMD_RESET       16'h0000
`define DFCR_FREQ_RESET      16'h0000
`define DFCR_INEN_RESET      16'h0000
`define DFCR_WORD_ZERO       16'h0000

`endif

// [hw/dfcr_pkg.sv]
// types shared by the drive fault and command register bank
package dfcr_pkg;
    typedef logic [15:0] dfcr_word_t;
    typedef enum logic [1:0] {
        ACC_IGNORE,
        ACC_READ,
        ACC_WRITE,
        ACC_BCAST_WRITE
    } dfcr_acc_t;
endpackage

// [hw/dfcr_fault_latch.sv]
// sixteen sticky flags, set by events, cleared together
`timescale 1ns/1ps
module dfcr_fault_latch (
    input  wire logic               mclk,
    input  wire logic               reset,
    input  wire logic               clk_en,
    input  wire dfcr_pkg::dfcr_word_t set_evt,
    input  wire logic               clear,
    output dfcr_pkg::dfcr_word_t    flags_ff
);
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_flag
            // set wins over the clear so no event is lost in the clearing cycle
            wire nxt_flag = set_evt[i] | (flags_ff[i] & ~clear);
            always_ff @(posedge mclk) begin
                if (reset) begin
                    flags_ff[i] <= 1'b0;
                end else if (clk_en) begin
                    flags_ff[i] <= nxt_flag;
                end
            end
        end
    endgenerate
endmodule

// [hw/dfcr_regs.sv]
// register bank: fault words, output current, run command word on the serial slave port
`timescale 1ns/1ps
`include "dfcr_consts.svh"
module dfcr_regs (
    // clock and register port
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire logic                 clk_en,
    input  wire logic [7:0]           station_addr,
    input  wire logic                 req_valid,
    input  wire logic [7:0]           req_slave,
    input  wire logic                 req_write,
    input  wire logic [15:0]          req_addr,
    input  wire dfcr_pkg::dfcr_word_t req_wdata,
    output logic                      rsp_valid,
    output dfcr_pkg::dfcr_word_t      rsp_data,
    output logic                      rsp_error,

    // first hardware fault word events
    input  wire logic                 adc_conversion_error,
    input  wire logic                 pwm_data_fault,
    input  wire logic                 board_spec_mismatch,
    input  wire logic                 terminal_board_comm_fault,
    input  wire logic                 eeprom_serial_comm_fault,
    input  wire logic                 ram_fault,
    input  wire logic                 flash_memory_fault,
    input  wire logic                 watchdog_exception,
    input  wire logic                 control_circuit_fault_a,

    // second hardware fault word events
    input  wire logic                 clock_fault,
    input  wire logic                 timing_fault,
    input  wire logic                 control_circuit_fault_b,
    input  wire logic                 control_circuit_fault_c,
    input  wire logic                 powerup_hw_fault,
    input  wire logic                 comm_startup_hw_fault,
    input  wire logic                 conversion_fault,
    input  wire logic                 pwm_feedback_fault,
    input  wire logic                 capacity_signal_fault,
    input  wire logic                 terminal_board_unconnected,

    // option card fault events
    input  wire logic                 option_incompatible,
    input  wire logic                 option_unconnected,
    input  wire logic                 option_selftest_error,
    input  wire logic                 option_flash_write_error,

    // communication errors kept in the log until a fault reset
    input  wire logic                 comm_crc_error,
    input  wire logic                 comm_parity_error,
    input  wire logic                 comm_framing_error,
    input  wire logic                 comm_overrun_error,
    input  wire logic                 comm_timeout_error,

    // measured current, already in hundredths of an ampere
    input  wire logic [15:0]          output_current_in,

    // drive commands
    output logic                      run_forward,
    output logic                      dir_reverse,
    output logic                      ext_fault_req,
    output logic                      fault_reset_pulse,
    output logic                      multifunction_input_5,
    output logic                      multifunction_input_6,
    output logic                      multifunction_input_7,
    output dfcr_pkg::dfcr_word_t      freq_ref
);

    dfcr_pkg::dfcr_word_t cmd_ff;
    dfcr_pkg::dfcr_word_t freq_ff;
    dfcr_pkg::dfcr_word_t inen_ff;
    dfcr_pkg::dfcr_word_t current_ff;
    dfcr_pkg::dfcr_word_t rsp_data_ff;
    logic                 rsp_valid_ff;
    logic                 rsp_error_ff;
    logic                 fault_reset_ff;

    dfcr_pkg::dfcr_word_t hw1_flags;
    dfcr_pkg::dfcr_word_t hw2_flags;
    dfcr_pkg::dfcr_word_t opt_flags;
    dfcr_pkg::dfcr_word_t log_flags;

    // ---------------- request decode
    // a frozen clock enable also drops the frame, so the master must retry
    wire                 take      = clk_en & req_valid;
    wire                 is_bcast  = (req_slave == `DFCR_BCAST_ADDR);
    // a station address of zero never claims addressed frames
    wire                 is_mine   = (req_slave == station_addr) &
                                     (station_addr != `DFCR_BCAST_ADDR);

    // broadcast reads have no owner; they are dropped silently
    wire dfcr_pkg::dfcr_acc_t acc_kind =
        (is_bcast & req_write) ? dfcr_pkg::ACC_BCAST_WRITE :
        (is_mine  & req_write) ? dfcr_pkg::ACC_WRITE :
        (is_mine)              ? dfcr_pkg::ACC_READ :
                                 dfcr_pkg::ACC_IGNORE;

    // full-width compares, so no word answers at an alias address
    wire hit_cmd     = (req_addr == `DFCR_ADDR_CMD);
    wire hit_freq    = (req_addr == `DFCR_ADDR_FREQ);
    wire hit_inen    = (req_addr == `DFCR_ADDR_INEN);
    wire hit_hw1     = (req_addr == `DFCR_ADDR_HW1);
    wire hit_hw2     = (req_addr == `DFCR_ADDR_HW2);
    wire hit_opt     = (req_addr == `DFCR_ADDR_OPT);
    wire hit_current = (req_addr == `DFCR_ADDR_CURRENT);
    wire hit_log     = (req_addr == `DFCR_ADDR_COMM_LOG);

    // only three words take writes; the rest answer with an error
    wire writable = hit_cmd | hit_freq | hit_inen;
    wire mapped   = writable | hit_hw1 | hit_hw2 | hit_opt | hit_current | hit_log;

    wire is_wr    = (acc_kind == dfcr_pkg::ACC_WRITE) |
                    (acc_kind == dfcr_pkg::ACC_BCAST_WRITE);
    wire is_rd    = (acc_kind == dfcr_pkg::ACC_READ);

    wire do_write = take & is_wr & writable;
    // only addressed frames are answered, broadcast never is
    wire respond  = take & ((acc_kind == dfcr_pkg::ACC_READ) |
                            (acc_kind == dfcr_pkg::ACC_WRITE));
    // a broadcast write to a read-only word is bad too, but respond keeps it silent
    wire bad_rd   = is_rd & ~mapped;
    wire bad_wr   = is_wr & ~writable;
    wire bad_acc  = bad_rd | bad_wr;

    wire wr_cmd   = do_write & hit_cmd;
    wire wr_freq  = do_write & hit_freq;
    wire wr_inen  = do_write & hit_inen;

    // ---------------- command word
    // reserved bits are masked on the way in, so they read back as zero
    wire dfcr_pkg::dfcr_word_t nxt_cmd  = wr_cmd  ? (req_wdata & `DFCR_CMD_MASK) : cmd_ff;
    wire dfcr_pkg::dfcr_word_t nxt_freq = wr_freq ? req_wdata : freq_ff;
    wire dfcr_pkg::dfcr_word_t nxt_inen = wr_inen ? (req_wdata & `DFCR_INEN_MASK) : inen_ff;

    // reset acts on the rising edge of the request bit; a held bit resets once
    wire nxt_fault_reset = wr_cmd & req_wdata[`DFCR_CMD_FRST_BIT] &
                           ~cmd_ff[`DFCR_CMD_FRST_BIT];

    always_ff @(posedge mclk) begin
        if (reset) begin
            cmd_ff <= `DFCR_CMD_RESET;
        end else if (clk_en) begin
            cmd_ff <= nxt_cmd;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            freq_ff <= `DFCR_FREQ_RESET;
        end else if (clk_en) begin
            freq_ff <= nxt_freq;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            inen_ff <= `DFCR_INEN_RESET;
        end else if (clk_en) begin
            inen_ff <= nxt_inen;
        end
    end

    // the pulse is a flop so the clear reaches every latch in the same cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            fault_reset_ff <= 1'b0;
        end else if (clk_en) begin
            fault_reset_ff <= nxt_fault_reset;
        end
    end

    // run, direction, external fault, fault reset and frequency outputs come straight from the flops, no decode in between
    assign run_forward   = cmd_ff[`DFCR_CMD_RUN_BIT];
    assign dir_reverse   = cmd_ff[`DFCR_CMD_DIR_BIT];
    assign ext_fault_req = cmd_ff[`DFCR_CMD_EXTF_BIT];
    assign fault_reset_pulse = fault_reset_ff;
    assign freq_ref      = freq_ff;

    // each input follows its command bit only while its enable bit is on
    assign multifunction_input_5 = cmd_ff[`DFCR_CMD_MFI5_BIT] & inen_ff[`DFCR_CMD_MFI5_BIT];
    assign multifunction_input_6 = cmd_ff[`DFCR_CMD_MFI6_BIT] & inen_ff[`DFCR_CMD_MFI6_BIT];
    assign multifunction_input_7 = cmd_ff[`DFCR_CMD_MFI7_BIT] & inen_ff[`DFCR_CMD_MFI7_BIT];

    // ---------------- fault event vectors
    // first word: reserved bits have no source, so they always read zero
    wire dfcr_pkg::dfcr_word_t hw1_set =
        ({15'h0000, adc_conversion_error}      << `DFCR_HW1_ADC_BIT)   |
        ({15'h0000, pwm_data_fault}            << `DFCR_HW1_PWMD_BIT)  |
        ({15'h0000, board_spec_mismatch}       << `DFCR_HW1_SPEC_BIT)  |
        ({15'h0000, terminal_board_comm_fault} << `DFCR_HW1_TBCOM_BIT) |
        ({15'h0000, eeprom_serial_comm_fault}  << `DFCR_HW1_EEP_BIT)   |
        ({15'h0000, ram_fault}                 << `DFCR_HW1_RAM_BIT)   |
        ({15'h0000, flash_memory_fault}        << `DFCR_HW1_FLASH_BIT) |
        ({15'h0000, watchdog_exception}        << `DFCR_HW1_WDOG_BIT)  |
        ({15'h0000, control_circuit_fault_a}   << `DFCR_HW1_CCA_BIT);

    // second word: bits A to F have no source and stay zero
    wire dfcr_pkg::dfcr_word_t hw2_set =
        ({15'h0000, clock_fault}                << `DFCR_HW2_CLK_BIT)   |
        ({15'h0000, timing_fault}               << `DFCR_HW2_TIM_BIT)   |
        ({15'h0000, control_circuit_fault_b}    << `DFCR_HW2_CCB_BIT)   |
        ({15'h0000, control_circuit_fault_c}    << `DFCR_HW2_CCC_BIT)   |
        ({15'h0000, powerup_hw_fault}           << `DFCR_HW2_PWRUP_BIT) |
        ({15'h0000, comm_startup_hw_fault}      << `DFCR_HW2_COMST_BIT) |
        ({15'h0000, conversion_fault}           << `DFCR_HW2_CONV_BIT)  |
        ({15'h0000, pwm_feedback_fault}         << `DFCR_HW2_PWMFB_BIT) |
        ({15'h0000, capacity_signal_fault}      << `DFCR_HW2_CAP_BIT)   |
        ({15'h0000, terminal_board_unconnected} << `DFCR_HW2_TBUNC_BIT);

    // option word: bit 2 has no source and stays zero
    wire dfcr_pkg::dfcr_word_t opt_set =
        ({15'h0000, option_incompatible}      << `DFCR_OPT_INCOMP_BIT) |
        ({15'h0000, option_unconnected}       << `DFCR_OPT_UNCON_BIT)  |
        ({15'h0000, option_selftest_error}    << `DFCR_OPT_SELF_BIT)   |
        ({15'h0000, option_flash_write_error} << `DFCR_OPT_FLASH_BIT);

    wire dfcr_pkg::dfcr_word_t log_set =
        ({15'h0000, comm_crc_error}     << `DFCR_LOG_CRC_BIT) |
        ({15'h0000, comm_parity_error}  << `DFCR_LOG_PAR_BIT) |
        ({15'h0000, comm_framing_error} << `DFCR_LOG_FRM_BIT) |
        ({15'h0000, comm_overrun_error} << `DFCR_LOG_OVR_BIT) |
        ({15'h0000, comm_timeout_error} << `DFCR_LOG_TMO_BIT);

    // sticky flags; only the fault reset pulse or reset clears them
    dfcr_fault_latch u_hw1 (
        .mclk     (mclk),
        .reset    (reset),
        .clk_en   (clk_en),
        .set_evt  (hw1_set & `DFCR_HW1_MASK),
        .clear    (fault_reset_ff),
        .flags_ff (hw1_flags)
    );

    dfcr_fault_latch u_hw2 (
        .mclk     (mclk),
        .reset    (reset),
        .clk_en   (clk_en),
        .set_evt  (hw2_set & `DFCR_HW2_MASK),
        .clear    (fault_reset_ff),
        .flags_ff (hw2_flags)
    );

    dfcr_fault_latch u_opt (
        .mclk     (mclk),
        .reset    (reset),
        .clk_en   (clk_en),
        .set_evt  (opt_set & `DFCR_OPT_MASK),
        .clear    (fault_reset_ff),
        .flags_ff (opt_flags)
    );

    // the log survives every frame, good or bad, until a fault reset
    dfcr_fault_latch u_log (
        .mclk     (mclk),
        .reset    (reset),
        .clk_en   (clk_en),
        .set_evt  (log_set & `DFCR_LOG_MASK),
        .clear    (fault_reset_ff),
        .flags_ff (log_flags)
    );

    // ---------------- output current
    // sampled every cycle with clk_en high so a read sees one coherent word, not a torn update
    always_ff @(posedge mclk) begin
        if (reset) begin
            current_ff <= `DFCR_WORD_ZERO;
        end else if (clk_en) begin
            current_ff <= output_current_in;
        end
    end

    // ---------------- read selection
    // unmapped numbers fall through to zero; bad_acc flags them as errors
    wire dfcr_pkg::dfcr_word_t rd_data =
        hit_cmd     ? cmd_ff :
        hit_freq    ? freq_ff :
        hit_inen    ? inen_ff :
        hit_hw1     ? hw1_flags :
        hit_hw2     ? hw2_flags :
        hit_opt     ? opt_flags :
        hit_current ? current_ff :
        hit_log     ? log_flags :
                      `DFCR_WORD_ZERO;

    // a write echoes the value now held, an error returns zero data
    wire dfcr_pkg::dfcr_word_t echo_data =
        hit_cmd  ? (req_wdata & `DFCR_CMD_MASK) :
        hit_inen ? (req_wdata & `DFCR_INEN_MASK) :
                   req_wdata;

    wire dfcr_pkg::dfcr_word_t nxt_rsp_data =
        bad_acc ? `DFCR_WORD_ZERO :
        is_rd   ? rd_data :
                  echo_data;

    // ---------------- response
    always_ff @(posedge mclk) begin
        if (reset) begin
            rsp_valid_ff <= 1'b0;
        end else if (clk_en) begin
            rsp_valid_ff <= respond;
        end
    end

    // error and data hold between answers, so a slow master can still read them
    always_ff @(posedge mclk) begin
        if (reset) begin
            rsp_error_ff <= 1'b0;
        end else if (respond) begin
            rsp_error_ff <= bad_acc;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rsp_data_ff <= `DFCR_WORD_ZERO;
        end else if (respond) begin
            rsp_data_ff <= nxt_rsp_data;
        end
    end

    assign rsp_valid = rsp_valid_ff;
    assign rsp_error = rsp_error_ff;
    assign rsp_data  = rsp_data_ff;

endmodule

// [sim/dfcr_master.sv]
// serial bus master model that issues frames into the register bank
`timescale 1ns/1ps
module dfcr_master (
    input  wire logic        mclk,
    output logic             req_valid,
    output logic [7:0]       req_slave,
    output logic             req_write,
    output logic [15:0]      req_addr,
    output logic [15:0]      req_wdata,
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_data,
    input  wire logic        rsp_error
);
    logic        got;
    logic [15:0] dat;
    logic        err;
    initial begin
        req_valid = 1'b0;
        req_slave = 8'h00;
        req_write = 1'b0;
        req_addr  = 16'h0000;
        req_wdata = 16'h0000;
    end
    // one frame per call; slave 00 is broadcast, which only writes and gets no answer
    task automatic xfer(input logic [7:0] sl, input logic wr, input logic [15:0] ad,
                        input logic [15:0] wd);
        @(posedge mclk);
        req_valid <= 1'b1;
        req_slave <= sl;
        req_write <= wr;
        req_addr  <= ad;
        req_wdata <= wd;
        @(posedge mclk);
        req_valid <= 1'b0;
        // idle address and data lines do not keep the last value, so stale data cannot pass
        req_addr  <= ~ad;
        req_wdata <= ~wd;
        #1;
        got = rsp_valid;
        dat = rsp_data;
        err = rsp_error;
    endtask
endmodule

// [sim/dfcr_regs_monitor.sv]
// port checks for the drive fault and command register bank
`timescale 1ns/1ps
`include "dfcr_consts.svh"
module dfcr_regs_monitor (
    input wire logic                 mclk,
    input wire logic                 reset,
    input wire logic                 clk_en,
    input wire logic [7:0]           station_addr,
    input wire logic                 req_valid,
    input wire logic [7:0]           req_slave,
    input wire logic                 req_write,
    input wire logic [15:0]          req_addr,
    input wire dfcr_pkg::dfcr_word_t req_wdata,
    input wire logic                 rsp_valid,
    input wire dfcr_pkg::dfcr_word_t rsp_data,
    input wire logic                 rsp_error,
    input wire logic                 adc_conversion_error,
    input wire logic [15:0]          output_current_in,
    input wire logic                 run_forward,
    input wire logic                 dir_reverse,
    input wire logic                 ext_fault_req,
    input wire logic                 fault_reset_pulse,
    input wire logic                 multifunction_input_5
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic take;
    logic own;
    logic cmd_wr;
    assign take   = req_valid && clk_en;
    assign own    = take && req_slave == station_addr && station_addr != 8'h00;
    assign cmd_wr = take && req_write && req_addr == `DFCR_ADDR_CMD && (own || req_slave == 8'h00);

    a_bcast_silent: assert property (take && req_slave == 8'h00 |=> !rsp_valid)
        else $error("broadcast frame was answered");
    a_own_answer: assert property (own |=> rsp_valid)
        else $error("addressed frame got no answer");
    a_run_bit: assert property (cmd_wr |=> run_forward == $past(req_wdata[0]))
        else $error("run output does not follow command bit 0");
    a_dir_bit: assert property (cmd_wr |=> dir_reverse == $past(req_wdata[1]))
        else $error("direction output does not follow command bit 1");
    a_ext_fault: assert property (cmd_wr |=> ext_fault_req == $past(req_wdata[4]))
        else $error("external fault output does not follow command bit 4");
    a_reset_cause: assert property (
        fault_reset_pulse |-> $past(cmd_wr) && $past(req_wdata[5]))
        else $error("fault reset pulse without a write of bit 5");
    a_mfi_gate: assert property (cmd_wr && !req_wdata[12] |=> !multifunction_input_5)
        else $error("input 5 high while command bit C is clear");
    a_cmd_echo: assert property (
        own && req_write && req_addr == `DFCR_ADDR_CMD
        |=> rsp_data == ($past(req_wdata) & `DFCR_CMD_MASK))
        else $error("command echo shows reserved bits");
    a_flag_seen: assert property (
        adc_conversion_error && clk_en ##1 own && !req_write && req_addr == `DFCR_ADDR_HW1
        |=> rsp_data[`DFCR_HW1_ADC_BIT])
        else $error("conversion fault flag not visible next cycle");
    a_current: assert property (
        own && !req_write && req_addr == `DFCR_ADDR_CURRENT && $past(clk_en) && !$past(reset)
        |=> rsp_data == $past(output_current_in, 2))
        else $error("current reading differs from input");
    a_rsp_single: assert property (clk_en && !own |=> !rsp_valid)
        else $error("answer without an addressed frame");
endmodule
bind dfcr_regs dfcr_regs_monitor u_dfcr_regs_monitor (.mclk, .reset, .clk_en, .station_addr,
    .req_valid, .req_slave, .req_write, .req_addr, .req_wdata, .rsp_valid, .rsp_data,
    .rsp_error, .adc_conversion_error, .output_current_in, .run_forward, .dir_reverse,
    .ext_fault_req, .fault_reset_pulse, .multifunction_input_5);

// [sim/tb_top.sv]
// self-checking bench for the drive fault and command register bank
`timescale 1ns/1ps
`include "dfcr_consts.svh"
module tb_top;
    localparam logic [7:0] STN = 8'h11;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        clk_en = 1'b1;
    logic [22:0] flt = '0;
    logic [4:0]  cerr = '0;
    logic [15:0] cur_in = 16'h0000;
    logic [6:0]  outs;
    logic [15:0] freq_ref, req_addr, req_wdata, rsp_data;
    logic [7:0]  req_slave;
    logic        req_valid, req_write, rsp_valid, rsp_error;
    logic [15:0] regs [7] = '{16'h0001, 16'h0002, 16'h000F, 16'h00D0, 16'h00D1, 16'h00D8, 16'h00FD};
    logic [15:0] fadr [4] = '{16'h00D0, 16'h00D1, 16'h00D8, 16'h00FD};
    int          fb [23] = '{2, 3, 6, 7, 8, 11, 12, 13, 14, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 0, 1, 3, 4};
    logic [15:0] ex [3];
    int          w;
    int          fails = 0;
    int          n_tests = 0;
    always #25 mclk = ~mclk;

    dfcr_master u_dfcr_master (.mclk(mclk), .req_valid(req_valid), .req_slave(req_slave),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error));
    dfcr_regs u_dfcr_regs (.mclk(mclk), .reset(reset), .clk_en(clk_en), .station_addr(STN),
        .req_valid(req_valid), .req_slave(req_slave), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_error(rsp_error),
        .adc_conversion_error(flt[0]), .pwm_data_fault(flt[1]), .board_spec_mismatch(flt[2]),
        .terminal_board_comm_fault(flt[3]), .eeprom_serial_comm_fault(flt[4]),
        .ram_fault(flt[5]), .flash_memory_fault(flt[6]), .watchdog_exception(flt[7]),
        .control_circuit_fault_a(flt[8]), .clock_fault(flt[9]), .timing_fault(flt[10]),
        .control_circuit_fault_b(flt[11]), .control_circuit_fault_c(flt[12]),
        .powerup_hw_fault(flt[13]), .comm_startup_hw_fault(flt[14]),
        .conversion_fault(flt[15]), .pwm_feedback_fault(flt[16]),
        .capacity_signal_fault(flt[17]), .terminal_board_unconnected(flt[18]),
        .option_incompatible(flt[19]), .option_unconnected(flt[20]),
        .option_selftest_error(flt[21]), .option_flash_write_error(flt[22]),
        .comm_crc_error(cerr[0]), .comm_parity_error(cerr[1]), .comm_framing_error(cerr[2]),
        .comm_overrun_error(cerr[3]), .comm_timeout_error(cerr[4]),
        .output_current_in(cur_in), .run_forward(outs[0]), .dir_reverse(outs[1]),
        .ext_fault_req(outs[2]), .fault_reset_pulse(outs[3]),
        .multifunction_input_5(outs[4]), .multifunction_input_6(outs[5]),
        .multifunction_input_7(outs[6]), .freq_ref(freq_ref));

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // addressed frame: an answer with this data and error flag must come back
    task automatic acc(input logic wr, input logic [15:0] ad, input logic [15:0] wd,
                       input logic [15:0] exp, input logic eerr);
        u_dfcr_master.xfer(STN, wr, ad, wd);
        chk("rsp_valid", 16'h0001, {15'h0, u_dfcr_master.got});
        chk($sformatf("rsp_data at %h", ad), exp, u_dfcr_master.dat);
        chk("rsp_error", {15'h0, eerr}, {15'h0, u_dfcr_master.err});
    endtask
    task automatic quiet(input logic [7:0] sl, input logic wr, input logic [15:0] ad,
                         input logic [15:0] wd);
        u_dfcr_master.xfer(sl, wr, ad, wd);
        chk("no answer", 16'h0000, {15'h0, u_dfcr_master.got});
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge mclk);
        fails++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        foreach (regs[i]) acc(1'b0, regs[i], 16'h0, 16'h0, 1'b0);
        chk("outputs", 16'h0000, {9'h0, outs});
        acc(1'b1, `DFCR_ADDR_CMD, 16'hFFFF, `DFCR_CMD_MASK, 1'b0);
        chk("run dir fault reset", 16'h000F, {9'h0, outs});
        acc(1'b1, `DFCR_ADDR_INEN, 16'hFFFF, `DFCR_INEN_MASK, 1'b0);
        chk("inputs enabled", 16'h0077, {9'h0, outs});
        acc(1'b1, `DFCR_ADDR_CMD, 16'h2002, 16'h2002, 1'b0);
        chk("input 6 reverse", 16'h0022, {9'h0, outs});
        // one event per pass; earlier flags must still read set
        foreach (ex[k]) ex[k] = 16'h0000;
        for (int i = 0; i < 23; i++) begin
            w = (i < 9) ? 0 : (i < 19) ? 1 : 2;
            ex[w][fb[i]] = 1'b1;
            @(posedge mclk);
            flt <= 23'h1 << i;
            acc(1'b0, fadr[w], 16'h0, ex[w], 1'b0);
        end
        @(posedge mclk);
        flt <= '0;
        cerr <= 5'h1F;
        @(posedge mclk);
        cerr <= 5'h00;
        repeat (20) @(posedge mclk);
        acc(1'b0, `DFCR_ADDR_COMM_LOG, 16'h0, `DFCR_LOG_MASK, 1'b0);
        quiet(8'h00, 1'b1, `DFCR_ADDR_CMD, 16'h0020);
        chk("broadcast fault reset", 16'h0008, {9'h0, outs});
        quiet(8'h00, 1'b1, `DFCR_ADDR_CMD, 16'h0020);
        chk("no second reset", 16'h0000, {9'h0, outs});
        foreach (fadr[i]) acc(1'b0, fadr[i], 16'h0, 16'h0, 1'b0);
        acc(1'b1, `DFCR_ADDR_HW1, 16'hFFFF, 16'h0000, 1'b1);
        acc(1'b0, 16'h0003, 16'h0, 16'h0000, 1'b1);
        quiet(8'h05, 1'b1, `DFCR_ADDR_FREQ, 16'h1111);
        quiet(8'h00, 1'b1, `DFCR_ADDR_FREQ, 16'h0BB8);
        chk("freq_ref", 16'h0BB8, freq_ref);
        quiet(8'h00, 1'b0, `DFCR_ADDR_FREQ, 16'h0000);
        @(posedge mclk);
        cur_in <= 16'h1234;
        acc(1'b0, `DFCR_ADDR_CURRENT, 16'h0, 16'h1234, 1'b0);
        @(posedge mclk);
        clk_en <= 1'b0;
        quiet(STN, 1'b1, `DFCR_ADDR_FREQ, 16'h0001);
        chk("frozen freq_ref", 16'h0BB8, freq_ref);
        @(posedge mclk);
        clk_en <= 1'b1;
        acc(1'b1, `DFCR_ADDR_CMD, 16'h0003, 16'h0003, 1'b0);
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        acc(1'b0, `DFCR_ADDR_CMD, 16'h0, 16'h0, 1'b0);
        chk("outputs after reset", 16'h0000, {9'h0, outs});
        chk("freq_ref after reset", 16'h0000, freq_ref);
        conclude();
    end
endmodule
